/* verilog/uhr_pkg.sv */
// Constants shared by the UART holding-register and interrupt-mask channel
package uhr_pkg;
    // Register addresses on the three-bit parallel address bus
    localparam logic [2:0] ADDR_HOLD   = 3'h0;
    localparam logic [2:0] ADDR_IMASK  = 3'h1;
    localparam logic [2:0] ADDR_FCTL   = 3'h2;
    localparam logic [2:0] ADDR_LSTAT  = 3'h5;
    // Reset values
    localparam logic [7:0] IMASK_RST   = 8'h00;
    localparam logic [1:0] TRIG_RST    = 2'h0;
    // Interrupt-mask bit positions
    localparam int IM_RX    = 0;
    localparam int IM_TX    = 1;
    localparam int IM_LINE  = 2;
    localparam int IM_MODEM = 3;
    // FIFO-control bit positions
    localparam int FC_EN     = 0;
    localparam int FC_RXRST  = 1;
    localparam int FC_TXRST  = 2;
    localparam int FC_TRIG_L = 6;
    // Line-status bit positions
    localparam int LS_DR   = 0;
    localparam int LS_OE   = 1;
    localparam int LS_PE   = 2;
    localparam int LS_FE   = 3;
    localparam int LS_BI   = 4;
    localparam int LS_THRE = 5;
    localparam int LS_TEMT = 6;
    localparam int LS_FERR = 7;
    // Interrupt-source codes, low nibble
    localparam logic [3:0] SRC_NONE  = 4'h1;
    localparam logic [3:0] SRC_LINE  = 4'h6;
    localparam logic [3:0] SRC_RX    = 4'h4;
    localparam logic [3:0] SRC_TX    = 4'h2;
    localparam logic [3:0] SRC_MODEM = 4'h0;
    // Receive trigger levels for field codes 0 to 3
    localparam logic [4:0] TRIG_LVL0 = 5'h01;
    localparam logic [4:0] TRIG_LVL1 = 5'h04;
    localparam logic [4:0] TRIG_LVL2 = 5'h08;
    localparam logic [4:0] TRIG_LVL3 = 5'h0e;
    // Timing: system clock and default line rate
    localparam int CLK_HZ   = 50000000;
    localparam int BAUD_BPS = 115200;
    localparam int TICK_DIV = CLK_HZ / (BAUD_BPS * 16);
    // Sample points in 16x ticks
    localparam logic [3:0] START_MID = 4'h7;
    localparam logic [3:0] BIT_END   = 4'hf;
    localparam int DATA_BITS = 8;
    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } uhr_rx_state_type;
endpackage

/* verilog/uhr_top.sv */
// UART channel: holding registers, shifters, start validation, interrupt mask
// Function
// [RQ1] One 8-bit holding stage feeds separate shifter
// [RQ2] Holding write passes bus byte to shifter
// [RQ3] Holding-empty flag sets on empty or transfer
// [RQ4] FIFO mode: flag zero when full only
// [RQ5] Holding read returns and removes oldest character
// [RQ6] Falling edge, count 16x, validate low centre
// [RQ7] Mask bits seven to four read zero
// [RQ8] Mask bit three gates modem-change interrupt
// [RQ9] Mask bit two gates receive-error interrupt
// [RQ10] Mask bit one gates transmit-empty interrupt
// [RQ11] Mask bit zero gates receive-ready interrupt
// [RQ12] Source shows receive trigger, clears below it
// [RQ13] Data-ready sets on push, clears when empty
// [RQ14] Transmit-empty interrupt cleared by source read, write
// [RQ15] All mask bits clear means no interrupt
// [RQ16] Polled status bits report errors and emptiness
// [RQ17] Enabled sources drive this channel's interrupt pin
// [RQ18] FIFO-enable bit selects single-character or FIFO operation
// [RQ19] Two-bit field selects receive trigger level
// [RQ20] Failed start bit discarded, search resumes
`timescale 1ns/1ns

module uhr_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input  wire logic                         clk_sys,   // System clock
    input  wire logic                         nrst,      // Async reset, low
    input  wire logic                         flush,     // Empty the buffer
    input  wire logic                         in_valid,  // Write request
    output logic                              in_ready,  // Space available
    input  wire logic [WIDTH-1:0]             in_data,   // Write data
    output logic                              out_valid, // Head valid
    input  wire logic                         out_ready, // Pop head
    output logic [WIDTH-1:0]                  out_data,  // Head data
    output logic [$clog2(DEPTH):0]            count      // Fill level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_ff;
    logic [AW-1:0]    rptr_ff;
    logic [AW:0]      cnt_ff;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rptr_ff];
    assign count     = cnt_ff;

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wptr_ff] <= in_data;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff  <= '0;
        end
        else if (flush)
        begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff  <= '0;
        end
        else
        begin
            wptr_ff <= push ? wptr_ff + 1'b1 : wptr_ff;
            rptr_ff <= pop ? rptr_ff + 1'b1 : rptr_ff;
            cnt_ff  <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module uhr_top
#(
    parameter int DEPTH    = 16,
    parameter int TICK_DIV = uhr_pkg::TICK_DIV
)
(
    input  wire logic       clk_sys,        // System clock, 50 MHz
    input  wire logic       nrst,           // Async reset, low
    input  wire logic       cs_n,           // Chip select, low
    input  wire logic [2:0] addr,           // Register address
    input  wire logic       rd_stb,         // Read strobe, one cycle
    input  wire logic       wr_stb,         // Write strobe, one cycle
    input  wire logic [7:0] wdata,          // Write data bus
    output logic      [7:0] rdata,          // Read data, registered
    input  wire logic [3:0] modem_delta,    // Modem change indicators
    input  wire logic       rxd,            // Serial receive line
    output logic            txd,            // Serial transmit line
    output logic            irq_channel_one,// Channel interrupt, high
    output logic            tx_space_ready, // Holding stage can take a byte
    output logic            rx_data_ready   // Receive data present
);
    localparam int CW = $clog2(DEPTH) + 1;

    logic [7:0]  imask_ff;
    logic        fifo_en_ff;
    logic [1:0]  trig_ff;
    logic [7:0]  rdata_ff;
    logic        overrun_ff;
    logic        ferr_ff;
    logic        tx_irq_ff;
    logic [15:0] div_ff;
    logic        tick_ff;
    logic        rxd_prev_ff;
    uhr_pkg::uhr_rx_state_type rx_st_ff;
    uhr_pkg::uhr_rx_state_type nxt_rx_st;
    logic [3:0]  rx_sub_ff;
    logic [3:0]  rx_bit_ff;
    logic [7:0]  rx_sh_ff;
    logic        tx_busy_ff;
    logic [9:0]  tx_sh_ff;
    logic [3:0]  tx_sub_ff;
    logic [3:0]  tx_bit_ff;

    // Bus decode
    wire sel        = !cs_n;
    wire wr_hold    = sel && wr_stb && (addr == uhr_pkg::ADDR_HOLD);
    wire wr_imask   = sel && wr_stb && (addr == uhr_pkg::ADDR_IMASK);
    wire wr_fctl    = sel && wr_stb && (addr == uhr_pkg::ADDR_FCTL);
    wire rd_hold    = sel && rd_stb && (addr == uhr_pkg::ADDR_HOLD);
    wire rd_src     = sel && rd_stb && (addr == uhr_pkg::ADDR_FCTL);
    wire rd_lstat   = sel && rd_stb && (addr == uhr_pkg::ADDR_LSTAT);
    // Toggling the FIFO enable also flushes, so stale bytes never cross modes
    wire mode_chg   = wr_fctl && (wdata[uhr_pkg::FC_EN] != fifo_en_ff);
    wire tx_flush   = wr_fctl && (wdata[uhr_pkg::FC_TXRST] || mode_chg);
    wire rx_flush   = wr_fctl && (wdata[uhr_pkg::FC_RXRST] || mode_chg);

    // Transmit path
    logic          tx_fifo_ready;
    logic          tx_valid;
    logic [7:0]    tx_head;
    logic [CW-1:0] tx_count;
    wire           tx_pop    = tx_valid && !tx_busy_ff;                     // [RQ1]
    // Without FIFOs only one character fits in the holding stage
    wire           tx_room   = fifo_en_ff ? tx_fifo_ready : (tx_count == '0); // [RQ18]
    wire           tx_push   = wr_hold && tx_room;                          // [RQ2]
    wire           tx_empty  = (tx_count == '0);

    uhr_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo
    (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .flush     (tx_flush),
        .in_valid  (tx_push),
        .in_ready  (tx_fifo_ready),
        .in_data   (wdata),
        .out_valid (tx_valid),
        .out_ready (!tx_busy_ff),
        .out_data  (tx_head),
        .count     (tx_count)
    );

    // Receive path, entries carry data plus framing and break flags
    logic          rx_fifo_ready;
    logic          rx_valid;
    logic [9:0]    rx_head;
    logic [CW-1:0] rx_count;
    logic          rx_push_req;
    logic [9:0]    rx_word;
    wire           rx_room   = fifo_en_ff ? rx_fifo_ready : (rx_count == '0);
    wire           rx_push   = rx_push_req && rx_room;
    wire           rx_lost   = rx_push_req && !rx_room;
    wire           rx_pop    = rd_hold && rx_valid;                         // [RQ5]
    wire           head_fe   = rx_valid && rx_head[8];
    wire           head_bi   = rx_valid && rx_head[9];

    uhr_fifo #(.WIDTH(10), .DEPTH(DEPTH)) u_rx_fifo
    (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .flush     (rx_flush),
        .in_valid  (rx_push),
        .in_ready  (rx_fifo_ready),
        .in_data   (rx_word),
        .out_valid (rx_valid),
        .out_ready (rx_pop),
        .out_data  (rx_head),
        .count     (rx_count)
    );

    // Status and interrupt sources
    wire [4:0] trig_lvl = (trig_ff == 2'h0) ? uhr_pkg::TRIG_LVL0 :
                          (trig_ff == 2'h1) ? uhr_pkg::TRIG_LVL1 :
                          (trig_ff == 2'h2) ? uhr_pkg::TRIG_LVL2 :
                                              uhr_pkg::TRIG_LVL3;           // [RQ19]
    wire rx_at_trig  = (CW'(trig_lvl) <= rx_count);
    wire rx_src      = fifo_en_ff ? rx_at_trig : rx_valid;                  // [RQ12]
    wire line_err    = overrun_ff || head_fe || head_bi;
    wire src_line    = imask_ff[uhr_pkg::IM_LINE] && line_err;              // [RQ9]
    wire src_rx      = imask_ff[uhr_pkg::IM_RX] && rx_src;                  // [RQ11]
    wire src_tx      = imask_ff[uhr_pkg::IM_TX] && tx_irq_ff;               // [RQ10]
    wire src_modem   = imask_ff[uhr_pkg::IM_MODEM] && (|modem_delta);       // [RQ8]
    wire [3:0] src_code = src_line  ? uhr_pkg::SRC_LINE  :
                          src_rx    ? uhr_pkg::SRC_RX    :
                          src_tx    ? uhr_pkg::SRC_TX    :
                          src_modem ? uhr_pkg::SRC_MODEM : uhr_pkg::SRC_NONE;
    wire tx_src_read = rd_src && (src_code == uhr_pkg::SRC_TX);
    // Transmit-empty event: the shifter took the last queued byte
    wire tx_drained  = tx_pop && (tx_count == CW'(1)) && !tx_push;
    wire thre        = fifo_en_ff ? tx_fifo_ready : tx_empty;               // [RQ3] [RQ4]
    wire temt        = tx_empty && !tx_busy_ff;
    wire [7:0] lstat = {ferr_ff, temt, thre, head_bi, head_fe, 1'b0,
                        overrun_ff, rx_valid};                              // [RQ13] [RQ16]
    wire [7:0] src_reg = {fifo_en_ff, fifo_en_ff, 2'b00, src_code};
    wire [7:0] rd_mux  = (addr == uhr_pkg::ADDR_HOLD)  ? rx_head[7:0] :
                         (addr == uhr_pkg::ADDR_IMASK) ? imask_ff :
                         (addr == uhr_pkg::ADDR_FCTL)  ? src_reg :
                         (addr == uhr_pkg::ADDR_LSTAT) ? lstat : 8'h00;

    assign irq_channel_one = src_line || src_rx || src_tx || src_modem;     // [RQ15] [RQ17]
    assign rdata           = rdata_ff;
    assign tx_space_ready  = tx_room;
    assign rx_data_ready   = rx_valid;
    assign txd             = tx_sh_ff[0];

    // Register file
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            imask_ff   <= uhr_pkg::IMASK_RST;
            fifo_en_ff <= 1'b0;
            trig_ff    <= uhr_pkg::TRIG_RST;
            rdata_ff   <= 8'h00;
        end
        else
        begin
            if (wr_imask)
                imask_ff <= {4'h0, wdata[3:0]};                             // [RQ7]
            if (wr_fctl)
            begin
                fifo_en_ff <= wdata[uhr_pkg::FC_EN];                        // [RQ18]
                trig_ff    <= wdata[uhr_pkg::FC_TRIG_L+1:uhr_pkg::FC_TRIG_L];
            end
            if (sel && rd_stb)
                rdata_ff <= rd_mux;
        end
    end

    // Sticky status; a new event in the clearing cycle wins
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            overrun_ff <= 1'b0;
            ferr_ff    <= 1'b0;
            tx_irq_ff  <= 1'b0;
        end
        else
        begin
            overrun_ff <= rx_lost || (overrun_ff && !rd_lstat);
            ferr_ff    <= (rx_push && (rx_word[8] || rx_word[9])) || (ferr_ff && !rd_lstat);
            tx_irq_ff  <= tx_drained || (tx_irq_ff && !tx_src_read && !tx_push); // [RQ14]
        end
    end

    // 16x sample tick
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            div_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (div_ff == 16'(TICK_DIV - 1));
            div_ff  <= (div_ff == 16'(TICK_DIV - 1)) ? 16'h0000 : div_ff + 16'h0001;
        end
    end

    // Receiver: 8 data bits, one stop bit, no parity
    always_comb
    begin
        nxt_rx_st   = rx_st_ff;
        rx_push_req = 1'b0;
        rx_word     = {!rxd && (rx_sh_ff == 8'h00), !rxd, rx_sh_ff};
        unique case (rx_st_ff)
            uhr_pkg::RX_IDLE:
                if (rxd_prev_ff && !rxd)
                    nxt_rx_st = uhr_pkg::RX_START;                          // [RQ6]
            uhr_pkg::RX_START:
                if (tick_ff && rx_sub_ff == uhr_pkg::START_MID)
                    nxt_rx_st = rxd ? uhr_pkg::RX_IDLE : uhr_pkg::RX_DATA;  // [RQ6] [RQ20]
            uhr_pkg::RX_DATA:
                if (tick_ff && rx_sub_ff == uhr_pkg::BIT_END
                    && rx_bit_ff == 4'(uhr_pkg::DATA_BITS - 1))
                    nxt_rx_st = uhr_pkg::RX_STOP;
            uhr_pkg::RX_STOP:
                if (tick_ff && rx_sub_ff == uhr_pkg::BIT_END)
                begin
                    nxt_rx_st   = uhr_pkg::RX_IDLE;
                    rx_push_req = 1'b1;
                end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_st_ff    <= uhr_pkg::RX_IDLE;
            rxd_prev_ff <= 1'b1;
            rx_sub_ff   <= 4'h0;
            rx_bit_ff   <= 4'h0;
            rx_sh_ff    <= 8'h00;
        end
        else
        begin
            rx_st_ff    <= nxt_rx_st;
            rxd_prev_ff <= rxd;
            if (rx_st_ff == uhr_pkg::RX_IDLE || nxt_rx_st != rx_st_ff)
            begin
                rx_sub_ff <= 4'h0;
                if (rx_st_ff != uhr_pkg::RX_DATA)
                    rx_bit_ff <= 4'h0;
            end
            else if (tick_ff)
                rx_sub_ff <= rx_sub_ff + 4'h1;
            if (rx_st_ff == uhr_pkg::RX_DATA && tick_ff && rx_sub_ff == uhr_pkg::BIT_END)
            begin
                rx_sh_ff  <= {rxd, rx_sh_ff[7:1]};
                rx_bit_ff <= rx_bit_ff + 4'h1;
            end
        end
    end

    // Transmitter shifter: start, 8 data bits lsb first, stop
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_busy_ff <= 1'b0;
            tx_sh_ff   <= 10'h3ff;
            tx_sub_ff  <= 4'h0;
            tx_bit_ff  <= 4'h0;
        end
        else if (tx_pop)
        begin
            tx_busy_ff <= 1'b1;
            tx_sh_ff   <= {1'b1, tx_head, 1'b0};                            // [RQ1]
            tx_sub_ff  <= 4'h0;
            tx_bit_ff  <= 4'h0;
        end
        else if (tx_busy_ff && tick_ff)
        begin
            tx_sub_ff <= tx_sub_ff + 4'h1;
            if (tx_sub_ff == uhr_pkg::BIT_END)
            begin
                tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
                tx_bit_ff <= tx_bit_ff + 4'h1;
                if (tx_bit_ff == 4'(uhr_pkg::DATA_BITS + 1))
                    tx_busy_ff <= 1'b0;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_mask_upper_zero;
        imask_ff[7:4] == 4'h0;
    endproperty
    a_mask_upper_zero: assert property (p_mask_upper_zero) // [RQ7]
        else $error("mask upper bits set");

    property p_thre_fifo;
        fifo_en_ff |-> (lstat[uhr_pkg::LS_THRE] == (tx_count != CW'(DEPTH)));
    endproperty
    a_thre_fifo: assert property (p_thre_fifo) else $error("holding-empty flag wrong"); // [RQ4]

    property p_data_ready;
        lstat[uhr_pkg::LS_DR] == (rx_count != '0);
    endproperty
    a_data_ready: assert property (p_data_ready) else $error("data-ready mismatch"); // [RQ13]

    property p_no_irq_masked;
        (imask_ff[3:0] == 4'h0) |-> !irq_channel_one;
    endproperty
    a_no_irq_masked: assert property (p_no_irq_masked) else $error("irq while masked"); // [RQ15]

    property p_false_start;
        (rx_st_ff == uhr_pkg::RX_START && tick_ff && rx_sub_ff == uhr_pkg::START_MID && rxd)
            |=> (rx_st_ff == uhr_pkg::RX_IDLE) && !rx_push_req;
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start kept"); // [RQ20]

    property p_rx_trig_irq;
        (fifo_en_ff && imask_ff[uhr_pkg::IM_RX] && rx_at_trig) |-> irq_channel_one;
    endproperty
    a_rx_trig_irq: assert property (p_rx_trig_irq) else $error("trigger irq missing"); // [RQ11]

    property p_tx_irq_clear;
        (tx_push && !tx_drained) |=> !tx_irq_ff;
    endproperty
    a_tx_irq_clear: assert property (p_tx_irq_clear) else $error("tx irq not cleared"); // [RQ14]

    property p_rx_pop;
        (rx_pop && !rx_push && !rx_flush) |=> (rx_count == $past(rx_count) - CW'(1));
    endproperty
    a_rx_pop: assert property (p_rx_pop) else $error("read did not remove byte"); // [RQ5]

    property p_temt;
        lstat[uhr_pkg::LS_TEMT] |-> (tx_count == '0) && !tx_busy_ff && txd;
    endproperty
    a_temt: assert property (p_temt) else $error("shifter empty flag wrong"); // [RQ16]

    c_rx_char:    cover property (rx_push);
    c_false_strt: cover property (rx_st_ff == uhr_pkg::RX_START ##1 rx_st_ff == uhr_pkg::RX_IDLE);
    c_tx_drain:   cover property (tx_drained ##1 irq_channel_one);
    c_overrun:    cover property (rx_lost);
endmodule

/* testbench/uhr_peer.sv */
// Serial line partner: sends frames into the receiver, collects transmitted bytes
`timescale 1ns/1ns

module uhr_peer
#(
    parameter int BIT = 16
)
(
    input  wire logic clk_sys, // System clock
    output logic      rxd,     // Line into the design, idle high
    input  wire logic txd      // Line out of the design
);
    logic [7:0] got_q[$];
    logic [7:0] sh;

    initial rxd = 1'b1;

    // Start, data low bit first, stop of chosen level, then idle high
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_sys);
            rxd <= f[i];
            repeat (BIT - 1) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        rxd <= 1'b1;
        repeat (2 * BIT) @(posedge clk_sys);
    endtask

    // Low pulse shorter than half a bit, must not count as a start
    task automatic glitch(input int n);
        @(posedge clk_sys);
        rxd <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rxd <= 1'b1;
        repeat (2 * BIT) @(posedge clk_sys);
    endtask

    // Samples mid-bit, away from the edges where the design moves txd
    always
    begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk_sys);
            sh[i] = txd;
        end
        got_q.push_back(sh);
        repeat (BIT) @(posedge clk_sys);
    end
endmodule

/* testbench/tb_uhr_top.sv */
// Self-checking bench for the UART holding-register channel
`timescale 1ns/1ns

`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module tb_uhr_top;
    logic       clk_sys = 1'b0;
    logic       nrst;
    logic       cs_n;
    logic [2:0] addr;
    logic       rd_stb;
    logic       wr_stb;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] modem_delta;
    logic       rxd;
    logic       txd;
    logic       irq;
    logic       tx_space_ready;
    logic       rx_data_ready;
    logic       rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] e;
    logic [7:0] vals[17];
    logic [31:0] rnd = 32'he5cf;
    int         checks = 0;
    int         bad_count = 0;
    int         cyc = 0;

    always #10 clk_sys = ~clk_sys;

    uhr_top #(.DEPTH(16), .TICK_DIV(1)) i_uhr_top (
        .clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .addr(addr), .rd_stb(rd_stb),
        .wr_stb(wr_stb), .wdata(wdata), .rdata(rdata), .modem_delta(modem_delta),
        .rxd(rxd), .txd(txd), .irq_channel_one(irq), .tx_space_ready(tx_space_ready),
        .rx_data_ready(rx_data_ready));

    uhr_peer #(.BIT(16)) i_uhr_peer (.clk_sys(clk_sys), .rxd(rxd), .txd(txd));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One bus cycle; a read notes its expected byte for the monitor
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cs_n   <= 1'b0;
        addr   <= a;
        wdata  <= d;
        wr_stb <= w;
        rd_stb <= !w;
        if (!w)
            exp_q.push_back(d);
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        cs_n   <= 1'b1;
    endtask

    task automatic wait_got(input int n);
        for (int i = 0; i < 4000 && i_uhr_peer.got_q.size() < n; i++)
            @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Read data is registered, so it is judged at the following falling edge
    always @(posedge clk_sys)
        rd_seen <= rd_stb & !cs_n;

    always @(negedge clk_sys)
        if (rd_seen && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            `CHK(rdata, e)
        end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    initial
    begin
        cs_n        = 1'b1;
        addr        = 3'h0;
        rd_stb      = 1'b0;
        wr_stb      = 1'b0;
        wdata       = 8'h00;
        modem_delta = 4'h0;
        nrst        = 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        `CHK({irq, tx_space_ready, rx_data_ready}, 3'b010)
        acc(0, uhr_pkg::ADDR_LSTAT, 8'h60);
        acc(1, uhr_pkg::ADDR_IMASK, 8'hff);
        acc(0, uhr_pkg::ADDR_IMASK, 8'h0f);
        rnd = lfsr(rnd);
        modem_delta <= rnd[3:0] | 4'h1;
        @(negedge clk_sys);
        `CHK(irq, 1'b1)
        acc(1, uhr_pkg::ADDR_IMASK, 8'h07);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        acc(1, uhr_pkg::ADDR_IMASK, 8'h01);
        modem_delta <= 4'h0;
        i_uhr_peer.glitch(4);
        @(negedge clk_sys);
        `CHK(rx_data_ready, 1'b0)
        rnd = lfsr(rnd);
        i_uhr_peer.send(rnd[7:0], 1'b1);
        @(negedge clk_sys);
        `CHK({irq, rx_data_ready}, 2'b11)
        acc(0, uhr_pkg::ADDR_HOLD, rnd[7:0]);
        acc(0, uhr_pkg::ADDR_LSTAT, 8'h60);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        // Single-character transmit and its empty event
        acc(1, uhr_pkg::ADDR_IMASK, 8'h02);
        acc(1, uhr_pkg::ADDR_HOLD, rnd[15:8]);
        wait_got(1);
        `CHK(i_uhr_peer.got_q[0], rnd[15:8])
        `CHK(irq, 1'b1)
        acc(0, uhr_pkg::ADDR_FCTL, 8'h02);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        // Buffered receive up to a trigger of four
        acc(1, uhr_pkg::ADDR_FCTL, 8'h41);
        acc(1, uhr_pkg::ADDR_IMASK, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            vals[i] = rnd[7:0];
            @(negedge clk_sys);
            `CHK(irq, 1'b0)
            i_uhr_peer.send(vals[i], 1'b1);
        end
        @(negedge clk_sys);
        `CHK(irq, 1'b1)
        acc(0, uhr_pkg::ADDR_FCTL, 8'hc4);
        for (int i = 0; i < 4; i++)
            acc(0, uhr_pkg::ADDR_HOLD, vals[i]);
        @(negedge clk_sys);
        `CHK({irq, rx_data_ready}, 2'b00)
        // Character with a low stop bit
        acc(1, uhr_pkg::ADDR_IMASK, 8'h04);
        i_uhr_peer.send(8'h5a, 1'b0);
        @(negedge clk_sys);
        `CHK(irq, 1'b1)
        acc(0, uhr_pkg::ADDR_LSTAT, 8'he9);
        acc(0, uhr_pkg::ADDR_HOLD, 8'h5a);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        // Fill the transmit buffer until it refuses, then let it drain
        acc(1, uhr_pkg::ADDR_IMASK, 8'h02);
        i_uhr_peer.got_q.delete();
        for (int i = 0; i < 17; i++)
        begin
            rnd = lfsr(rnd);
            vals[i] = rnd[7:0];
            acc(1, uhr_pkg::ADDR_HOLD, vals[i]);
        end
        @(negedge clk_sys);
        `CHK(tx_space_ready, 1'b0)
        acc(1, uhr_pkg::ADDR_HOLD, 8'hff);
        wait_got(17);
        repeat (200) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(i_uhr_peer.got_q.size(), 17)
        for (int i = 0; i < 17; i++)
            `CHK(i_uhr_peer.got_q[i], vals[i])
        `CHK({irq, tx_space_ready}, 2'b11)
        // Polled mode: transmit-empty pending and modem change raised, yet no interrupt
        acc(1, uhr_pkg::ADDR_IMASK, 8'h00);
        rnd = lfsr(rnd);
        modem_delta <= rnd[3:0] | 4'h1;
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        acc(1, uhr_pkg::ADDR_IMASK, 8'h02);
        modem_delta <= 4'h0;
        acc(0, uhr_pkg::ADDR_FCTL, 8'hc2);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        // Back to single-character mode: a break, then a byte that is lost
        acc(1, uhr_pkg::ADDR_FCTL, 8'h00);
        acc(1, uhr_pkg::ADDR_IMASK, 8'h04);
        i_uhr_peer.send(8'h00, 1'b0);
        rnd = lfsr(rnd);
        i_uhr_peer.send(rnd[7:0], 1'b1);
        @(negedge clk_sys);
        `CHK({irq, rx_data_ready}, 2'b11)
        acc(0, uhr_pkg::ADDR_LSTAT, 8'hfb);
        acc(0, uhr_pkg::ADDR_HOLD, 8'h00);
        @(negedge clk_sys);
        `CHK({irq, rx_data_ready}, 2'b00)
        give_verdict();
    end
endmodule
